// file: hw/mcsp_pkg.sv
// Constants and types shared by the main clock select and prescale block.
package mcsp_pkg;

  // Register indices; the bus byte address is four times the index.
  localparam logic [7:0] IDX_MCA = 8'h00;
  localparam logic [7:0] IDX_MCB = 8'h01;
  localparam logic [7:0] IDX_LOCK = 8'h02;
  localparam logic [7:0] IDX_STAT = 8'h03;
  localparam logic [7:0] IDX_FCA = 8'h10;
  localparam logic [7:0] IDX_TRIM = 8'h11;
  // Index used for any out of range or misaligned access.
  localparam logic [7:0] IDX_NONE = 8'hff;

  // Reset values of the plain registers.
  localparam logic [7:0] MCA_RST = 8'h00;
  localparam logic [7:0] MCB_RST = 8'h11;
  localparam logic [7:0] FCA_RST = 8'h00;

  // Field positions.
  localparam int MCA_OUT_BIT = 7;
  localparam int MCB_ON_BIT = 0;
  localparam int MCB_RATIO_LSB = 1;
  localparam int LOCK_BIT = 0;
  localparam int FCA_KEEP_BIT = 1;
  localparam int ST_STABLE_LSB = 4;
  localparam int ST_SW_BIT = 0;

  // Source gate delays in source cycles, and the unlock window length.
  localparam logic [2:0] GATE_OSC_CYC = 3'h4;
  localparam logic [2:0] GATE_EXT_CYC = 3'h2;
  localparam logic [2:0] CCP_INSTR = 3'h4;

  // Factory trim values picked by the frequency select fuse.
  localparam logic [6:0] TRIM_FACTORY_0 = 7'h40;
  localparam logic [6:0] TRIM_FACTORY_1 = 7'h48;

  // Main clock sources.
  typedef enum logic [1:0] {
    SRC_FAST = 2'b00,
    SRC_ULP = 2'b01,
    SRC_XTAL = 2'b10,
    SRC_EXT = 2'b11
  } mcsp_src_t;

  // Source switch sequencer.
  typedef enum logic [0:0] {
    SW_IDLE = 1'b0,
    SW_WAIT = 1'b1
  } mcsp_sw_t;

  // Software visible control fields.
  typedef struct packed {
    logic out_en;
    mcsp_src_t sel;
    logic [3:0] ratio;
    logic pre_on;
    logic lock;
    logic keep;
    logic [6:0] trim;
  } mcsp_regs_t;

  // Whole state of the top module.
  typedef struct packed {
    mcsp_regs_t r;
    mcsp_src_t cur;
    mcsp_sw_t sw;
    logic [2:0] change_protection;
    logic wr_pend;
    logic [7:0] widx;
    logic [7:0] rdata;
    logic ready;
    logic [3:0][2:0] gcnt;
    logic [3:0] en;
    logic [3:0] dlv;
    logic main_tick;
    logic pin;
  } mcsp_state_t;

  // Whole state of the prescaler.
  typedef struct packed {
    logic [5:0] cnt;
    logic [5:0] term;
    logic tick;
  } mcsp_pre_t;

  // Terminal count (divisor minus one) of a ratio code.
  function automatic logic [5:0] mcsp_term(input logic [3:0] code);
    logic [5:0] t;
    t = 6'h01;
    case (code)
      4'h0: t = 6'h01;
      4'h1: t = 6'h03;
      4'h2: t = 6'h07;
      4'h3: t = 6'h0f;
      4'h4: t = 6'h1f;
      4'h5: t = 6'h3f;
      4'h8: t = 6'h05;
      4'h9: t = 6'h09;
      4'ha: t = 6'h0b;
      4'hb: t = 6'h17;
      4'hc: t = 6'h2f;
      default: t = 6'h01;
    endcase
    return t;
  endfunction

endpackage

// file: hw/mcsp_prescaler.sv
// Peripheral clock prescaler driven by main clock enable pulses.
`timescale 1ns/10ps
`default_nettype none
module mcsp_prescaler
  import mcsp_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic main_tick, // One pulse per main clock cycle.
  input wire logic prescaler_on, // Divide when high.
  input wire logic [3:0] prescaler_ratio, // Ratio code.
  output logic per_tick // One pulse per peripheral clock.
);

  mcsp_pre_t q; // Registered state.
  mcsp_pre_t d; // Next state.

  // A new ratio or on/off setting is taken only at a period boundary,
  // so no peripheral period is ever shorter than old or new one.
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (main_tick) begin
      if (q.cnt >= q.term) begin
        d.cnt = 6'h00;
        d.tick = 1'b1;
        if (prescaler_on) begin
          d.term = mcsp_term(prescaler_ratio);
        end else begin
          d.term = 6'h00;
        end
      end else begin
        d.cnt = q.cnt + 6'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      q.cnt <= 6'h00;
      q.term <= mcsp_term(MCB_RST[4:1]);
      q.tick <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign per_tick = q.tick;

endmodule
`default_nettype wire

// file: hw/mcsp_top.sv
// Main clock select, prescale and control registers on an AHB-Lite slave.
`timescale 1ns/10ps
`default_nettype none
module mcsp_top
  import mcsp_pkg::*;
(
  input wire logic clk, // System clock, 20 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size, word only.
  input wire logic hready, // Bus ready.
  input wire logic [31:0] hwdata, // Write data.
  output logic [31:0] hrdata, // Read data.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Response, always OKAY.
  input wire logic ccp_key_written, // Pulse: unlock key accepted.
  input wire logic instr_retired, // Pulse: one instruction done.
  input wire logic fuse_lock_bit, // Lock fuse level.
  input wire logic fuse_frequency_select, // Frequency fuse level.
  input wire logic [3:0] src_tick, // Source clock edge pulses.
  input wire logic [3:0] osc_analog_ready, // Analog start done.
  input wire logic [3:0] other_request, // Other module requests.
  input wire logic sleeping, // Device is in a sleep mode.
  input wire logic periph_uses_sysclk, // Peripheral needs clock.
  output logic [3:0] osc_enable, // Source power requests.
  output logic [3:0] osc_deliver, // Source gates open.
  output logic main_tick, // Main clock pulse.
  output logic per_tick, // Peripheral clock pulse.
  output logic clk_out_pin, // System clock pin.
  output logic [6:0] fast_trim // Fast oscillator trim.
);

  mcsp_state_t q; // Registered state.
  mcsp_state_t d; // Next state.
  mcsp_state_t rst_s; // Value loaded at reset.
  logic [3:0] req; // Per-source request.
  logic [3:0] stable; // Per-source stable flag.
  logic unlocked; // Change protection window open.
  logic take; // Address phase accepted.
  logic [7:0] aidx; // Decoded register index.
  logic [7:0] wb; // Written byte.
  logic [7:0] rd; // Read mux.
  logic [2:0] glim; // Gate delay of a source.
  logic aok; // Analog start satisfied.

  // Reset image; lock and trim come from the fuses, which is safe here
  // because the reset is synchronous.
  always_comb begin
    rst_s = '0;
    rst_s.r.out_en = MCA_RST[MCA_OUT_BIT];
    rst_s.r.sel = mcsp_src_t'(MCA_RST[1:0]);
    rst_s.r.pre_on = MCB_RST[MCB_ON_BIT];
    rst_s.r.ratio = MCB_RST[4:1];
    rst_s.r.keep = FCA_RST[FCA_KEEP_BIT];
    rst_s.r.lock = fuse_lock_bit;
    rst_s.r.trim = fuse_frequency_select ? TRIM_FACTORY_1
                                         : TRIM_FACTORY_0;
    rst_s.cur = mcsp_src_t'(MCA_RST[1:0]);
    rst_s.sw = SW_IDLE;
    rst_s.widx = IDX_NONE;
    rst_s.ready = 1'b1;
  end

  // Requests: the selected source, the source still running the main
  // clock during a switch, and any other module's request.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      req[i] = other_request[i] || (q.r.sel == mcsp_src_t'(i)) ||
               (q.cur == mcsp_src_t'(i));
      stable[i] = req[i] && q.dlv[i];
    end
  end

  // Address phase decode; misaligned or out of range goes nowhere.
  always_comb begin
    take = hsel && htrans[1] && hready;
    if (haddr[31:10] == 22'h000000 && haddr[1:0] == 2'b00) begin
      aidx = haddr[9:2];
    end else begin
      aidx = IDX_NONE;
    end
    wb = hwdata[7:0];
    unlocked = (q.change_protection != 3'h0);
  end

  // Next state.
  always_comb begin
    d = q;
    d.main_tick = 1'b0;
    d.ready = 1'b1;
    glim = GATE_OSC_CYC;
    aok = 1'b0;

    // Unlock window: opened by the key, closed after four instructions.
    if (ccp_key_written) begin
      d.change_protection = CCP_INSTR;
    end else if (instr_retired && unlocked) begin
      d.change_protection = q.change_protection - 3'h1;
    end

    // Data phase of a write. Every register here needs the open window;
    // otherwise the target is left as it is.
    if (q.wr_pend && unlocked) begin
      d.change_protection = 3'h0;
      case (q.widx)
        IDX_MCA: begin
          if (!q.r.lock) begin
            d.r.out_en = wb[MCA_OUT_BIT];
            d.r.sel = mcsp_src_t'(wb[1:0]);
          end
        end
        IDX_MCB: begin
          if (!q.r.lock) begin
            d.r.pre_on = wb[MCB_ON_BIT];
            d.r.ratio = wb[MCB_RATIO_LSB +: 4];
          end
        end
        IDX_LOCK: begin
          if (!q.r.lock) begin
            d.r.lock = wb[LOCK_BIT];
          end
        end
        IDX_FCA: begin
          d.r.keep = wb[FCA_KEEP_BIT];
        end
        IDX_TRIM: begin
          // Trim of the fast source is frozen only while locked and it runs main.
          if (!(q.r.lock && q.cur == SRC_FAST)) begin
            d.r.trim = wb[6:0];
          end
        end
        default: begin
          d.change_protection = d.change_protection;
        end
      endcase
    end

    // Address phase capture.
    d.wr_pend = take && hwrite;
    d.widx = take ? aidx : IDX_NONE;

    // Per-source gates. The count runs on source edges once the analog
    // start is done; keep-running skips that wait for the fast source.
    for (int i = 0; i < 4; i++) begin
      glim = (i == 3) ? GATE_EXT_CYC : GATE_OSC_CYC;
      aok = osc_analog_ready[i] ||
            (i == 0 && q.r.keep);
      d.en[i] = req[i] || (i == 0 && q.r.keep);
      if (!req[i]) begin
        d.gcnt[i] = 3'h0;
        d.dlv[i] = 1'b0;
      end else if (!q.dlv[i] && aok && src_tick[i]) begin
        d.gcnt[i] = q.gcnt[i] + 3'h1;
        if (q.gcnt[i] + 3'h1 >= glim) begin
          d.dlv[i] = 1'b1;
        end
      end
    end

    // Switch sequencer: move to the new source only when it is stable,
    // and on an edge of the old one or while the old gate is closed, so no short main period appears.
    case (q.sw)
      SW_IDLE: begin
        if (q.r.sel != q.cur) begin
          d.sw = SW_WAIT;
        end
      end
      SW_WAIT: begin
        if (q.r.sel == q.cur) begin
          d.sw = SW_IDLE;
        end else if (stable[q.r.sel] &&
                     (src_tick[q.cur] || !q.dlv[q.cur])) begin
          d.cur = q.r.sel;
          d.sw = SW_IDLE;
        end
      end
      default: begin
        d.sw = SW_IDLE;
      end
    endcase

    // Main clock pulse from the current source, only through its gate.
    d.main_tick = src_tick[q.cur] && q.dlv[q.cur];

    // Pin copy of the system clock, quiet in sleep unless still in use.
    d.pin = q.r.out_en && per_tick &&
            (!sleeping || periph_uses_sysclk);

    // Read mux built from the post-write value, so a read right after a
    // write returns the new contents.
    rd = 8'h00;
    case (aidx)
      IDX_MCA: rd = {d.r.out_en, 5'h00, d.r.sel};
      IDX_MCB: rd = {3'h0, d.r.ratio, d.r.pre_on};
      IDX_LOCK: rd = q.r.lock ? 8'h00 : {7'h00, d.r.lock};
      IDX_STAT: rd = {stable, 3'h0,
                      q.sw == SW_WAIT};
      IDX_FCA: rd = {6'h00, d.r.keep, 1'b0};
      IDX_TRIM: rd = {1'b0, d.r.trim};
      default: rd = 8'h00;
    endcase
    if (take && !hwrite) begin
      d.rdata = rd;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= rst_s;
    end else begin
      q <= d;
    end
  end

  // Peripheral clock divider fed by the main clock pulse.
  mcsp_prescaler u_pre (
    .clk(clk),
    .rst(rst),
    .main_tick(q.main_tick),
    .prescaler_on(q.r.pre_on),
    .prescaler_ratio(q.r.ratio),
    .per_tick(per_tick)
  );

  // Outputs, all but the constant hresp and the prescaler's per_tick taken from the state register.
  assign hrdata = {24'h000000, q.rdata};
  assign hreadyout = q.ready;
  assign hresp = 1'b0;
  assign osc_enable = q.en;
  assign osc_deliver = q.dlv;
  assign main_tick = q.main_tick;
  assign clk_out_pin = q.pin;
  assign fast_trim = q.r.trim;

endmodule
`default_nettype wire

// file: tb/mcsp_properties.sv
// Port checks for the main clock select and prescale block.
`timescale 1ns/10ps
`default_nettype none
module mcsp_properties (
  input wire logic clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic hsel, // Select.
  input wire logic [1:0] htrans, // Transfer.
  input wire logic hwrite, // Write.
  input wire logic hready, // Ready in.
  input wire logic [31:0] hrdata, // Read data.
  input wire logic hreadyout, // Ready out.
  input wire logic hresp, // Response.
  input wire logic [3:0] src_tick, // Source ticks.
  input wire logic [3:0] osc_analog_ready, // Analog ready.
  input wire logic [3:0] osc_deliver, // Gates.
  input wire logic main_tick, // Main pulse.
  input wire logic per_tick, // Peripheral pulse.
  input wire logic clk_out_pin, // Clock pin.
  input wire logic sleeping, // Asleep.
  input wire logic periph_uses_sysclk, // Clock user.
  input wire logic [6:0] fast_trim // Trim.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A write address phase taken; trim may only move one edge later.
  logic wr_acc;
  assign wr_acc = hsel & htrans[1] & hwrite & hready;
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  ready_high_a: assert property (hreadyout == 1'b1)
    else $error("slave inserted a wait");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  pin_sleep_a: assert property ($past(sleeping && !periph_uses_sysclk) |-> !clk_out_pin)
    else $error("clock pin pulsed in sleep");
  pin_src_a: assert property (clk_out_pin |-> $past(per_tick))
    else $error("clock pin without system clock");
  main_gate_a: assert property (main_tick |-> $past(|(src_tick & osc_deliver)))
    else $error("main pulse without gated source tick");
  ulp_gate_a: assert property ($rose(osc_deliver[1]) |-> $past(osc_analog_ready[1]))
    else $error("gate opened before source ready");
  // The write lands at the data phase edge, so the address phase that
  // carried it lies two sampled edges before the trim is seen changed.
  trim_write_a: assert property ($changed(fast_trim) |->
    $past(wr_acc, 2))
    else $error("trim moved without a write");
  cover property (per_tick);
  cover property (clk_out_pin);
  cover property ($rose(osc_deliver[1]));
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the main clock select and prescale block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import mcsp_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic ccp_key_written = 1'b0, instr_retired = 1'b0, fuse_lock_bit = 1'b0;
  logic sleeping = 1'b0, periph_uses_sysclk = 1'b0;
  logic fuse_frequency_select = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [3:0] src_tick = 4'h0, other_request = 4'h0, osc_enable, osc_deliver;
  logic hreadyout, hresp, main_tick, per_tick, clk_out_pin;
  logic [6:0] fast_trim;
  int fail_count = 0;
  int total_checks = 0;
  // A 20 MHz clock; every source ticks on alternate cycles.
  always #25 clk = ~clk;
  always @(posedge clk) src_tick <= ~src_tick;
  mcsp_top i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ccp_key_written(ccp_key_written), .instr_retired(instr_retired),
    .fuse_lock_bit(fuse_lock_bit),
    .fuse_frequency_select(fuse_frequency_select),
    .src_tick(src_tick), .osc_analog_ready(4'hf),
    .other_request(other_request), .sleeping(sleeping),
    .periph_uses_sysclk(periph_uses_sysclk), .osc_enable(osc_enable),
    .osc_deliver(osc_deliver), .main_tick(main_tick), .per_tick(per_tick),
    .clk_out_pin(clk_out_pin), .fast_trim(fast_trim));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  // A used-up wait limit ends the run as a mismatch.
  task automatic bound(input int n);
    if (n >= 2000) begin
      $display("unexpected wait limit reached");
      fail_count++;
      finish_test();
    end
  endtask
  // One AHB single word transfer; held until ready is seen high.
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 2000);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 2000);
    bound(n);
    rd = hrdata[7:0];
  endtask
  task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] v;
    xfer(1'b0, idx, 8'h00, v);
    chk(nm, e, v);
  endtask
  // Unlock key pulse, then the protected write.
  task automatic pw(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] v;
    @(posedge clk);
    ccp_key_written <= 1'b1;
    @(posedge clk);
    ccp_key_written <= 1'b0;
    xfer(1'b1, idx, d, v);
  endtask
  // Main pulses in one full peripheral period.
  task automatic per_n(output int m);
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (per_tick !== 1'b1 && n < 2000);
    m = 0;
    do begin @(posedge clk); n++; m += main_tick; end while (per_tick !== 1'b1 && n < 2000);
    bound(n);
  endtask
  task automatic rst_dut(input logic f);
    rst <= 1'b1;
    fuse_lock_bit <= f;
    fuse_frequency_select <= f;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic t_reset;
    rdc("ctrl a", IDX_MCA, MCA_RST);
    rdc("ctrl b", IDX_MCB, MCB_RST);
    rdc("lock", IDX_LOCK, 8'h00);
    rdc("fast ctrl", IDX_FCA, FCA_RST);
    rdc("trim", IDX_TRIM, {1'b0, TRIM_FACTORY_0});
    rdc("unmapped", 8'h05, 8'h00);
    $display("test reset values done");
  endtask
  task automatic t_protect;
    logic [7:0] v;
    xfer(1'b1, IDX_MCB, 8'h19, v);
    rdc("bare write", IDX_MCB, MCB_RST);
    @(posedge clk);
    ccp_key_written <= 1'b1;
    @(posedge clk);
    ccp_key_written <= 1'b0;
    repeat (4) begin @(posedge clk); instr_retired <= 1'b1; end
    @(posedge clk);
    instr_retired <= 1'b0;
    xfer(1'b1, IDX_MCB, 8'h19, v);
    rdc("late write", IDX_MCB, MCB_RST);
    $display("test protection done");
  endtask
  task automatic t_ratio;
    logic [3:0] cd [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                            4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
    int dv [11] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48};
    int m;
    for (int i = 0; i < 11; i++) begin
      pw(IDX_MCB, {3'h0, cd[i], 1'b1});
      per_n(m);
      per_n(m);
      chk("divide", dv[i][7:0], m[7:0]);
    end
    pw(IDX_MCB, 8'h18);
    per_n(m);
    per_n(m);
    chk("undivided", 8'h01, m[7:0]);
    $display("test prescaler done");
  endtask
  task automatic t_switch;
    logic [7:0] v;
    int n;
    pw(IDX_MCA, 8'h81);
    n = 0;
    do begin xfer(1'b0, IDX_STAT, 8'h00, v); n++; end while (v[0] !== 1'b0 && n < 2000);
    bound(n);
    chk("status ulp", 8'h20, v);
    chk("ulp gate", 8'h02, {4'h0, osc_deliver});
    pw(IDX_FCA, 8'h02);
    repeat (20) @(posedge clk);
    chk("keep on", 8'h01, {4'h0, osc_enable & 4'h1});
    chk("keep no gate", 8'h02, {4'h0, osc_deliver});
    rdc("keep status", IDX_STAT, 8'h20);
    other_request <= 4'h8;
    n = 0;
    do begin xfer(1'b0, IDX_STAT, 8'h00, v); n++; end while (v[7] !== 1'b1 && n < 2000);
    bound(n);
    chk("ext started", 8'ha0, v);
    n = 0;
    do begin @(posedge clk); n++; end while (clk_out_pin !== 1'b1 && n < 2000);
    bound(n);
    chk("pin out", 8'h01, {7'h0, clk_out_pin});
    sleeping <= 1'b1;
    repeat (2) @(posedge clk);
    n = 0;
    repeat (40) begin @(posedge clk); n += clk_out_pin; end
    chk("sleep pin", 8'h00, n[7:0]);
    periph_uses_sysclk <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (clk_out_pin !== 1'b1 && n < 2000);
    bound(n);
    sleeping <= 1'b0;
    periph_uses_sysclk <= 1'b0;
    $display("test source switch done");
  endtask
  task automatic t_lock;
    pw(IDX_TRIM, 8'h55);
    // The trim output settles after the edge that wrote it.
    @(negedge clk);
    chk("trim pin", 8'h55, {1'b0, fast_trim});
    pw(IDX_LOCK, 8'h01);
    pw(IDX_MCA, 8'h00);
    rdc("locked a", IDX_MCA, 8'h81);
    rdc("locked lock", IDX_LOCK, 8'h00);
    pw(IDX_LOCK, 8'h00);
    pw(IDX_MCB, 8'h11);
    rdc("still locked", IDX_MCB, 8'h18);
    rst_dut(1'b1);
    rdc("fuse trim", IDX_TRIM, {1'b0, TRIM_FACTORY_1});
    pw(IDX_MCB, 8'h13);
    rdc("fuse lock", IDX_MCB, MCB_RST);
    rst_dut(1'b0);
    pw(IDX_MCB, 8'h13);
    rdc("unlocked", IDX_MCB, 8'h13);
    $display("test lock done");
  endtask
  initial begin
    rst_dut(1'b0);
    t_reset();
    t_protect();
    t_ratio();
    t_switch();
    t_lock();
    finish_test();
  end
endmodule
bind mcsp_top mcsp_properties i_chk (.clk(clk), .rst(rst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .src_tick(src_tick),
  .osc_analog_ready(osc_analog_ready), .osc_deliver(osc_deliver),
  .main_tick(main_tick), .per_tick(per_tick), .clk_out_pin(clk_out_pin),
  .sleeping(sleeping), .periph_uses_sysclk(periph_uses_sysclk),
  .fast_trim(fast_trim));
`default_nettype wire
